// >>> bst_test_port.sv
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "bst_cfg.svh"

// Overview of operation
// - Four test pins only; reconfigure pin resets all test logic and state machine.
// - Three-bit instruction register, eight codes; code 011 is reserved.
// - Code 000 external test, 100 sample/preload, 111 bypass.
// - Codes 001 and 101 each route one internal scan ring through.
// - Code 010 streams test data in into configuration memory.
// - Code 110 shifts memory contents out once configuration is done.
// - Each pad has output and 3-state bits; enabled drives, else captures pad.
// - Sample captures each 3-state control, and per control the pad level or core data, in one cycle.
// - All pads except config clock, done and test pins are in chain.
// - Chain runs clockwise from top-left pad to topmost left-edge pad.
// - Bypass is one flop; each boundary pad adds two flop stages.
// - Test logic active before and during configuration; option decides after.
// - No identification register; nothing identifies the part.
// - Disabled after configuration, pins become user I/O; output floats or readback.
// - Test output shares one pad with configuration readback data.
// - Inputs sampled on rising test clock; output changes on falling edge.
// - External-test values reach the pads on the falling test clock edge.
// - Output select high for external test, low for bypass or sample.
// - Control cell flag picks pad input (low) or core data (high).
module bst_test_port
  import bst_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic reconfigure_pin_n_i,
  input wire logic config_done_i,
  input wire logic readback_data_i,
  output logic user_io_en_o,
  input wire logic [`BST_NUM_PADS-1:0] pad_in_i,
  input wire logic [`BST_NUM_PADS-1:0] core_out_i,
  input wire logic [`BST_NUM_PADS-1:0] core_oe_i,
  output logic [`BST_NUM_PADS-1:0] pad_out_o,
  output logic [`BST_NUM_PADS-1:0] pad_oe_o,
  output logic ring_si_o,
  output logic ring1_capture_o,
  output logic ring1_shift_o,
  output logic ring1_update_o,
  input wire logic ring1_so_i,
  output logic ring2_capture_o,
  output logic ring2_shift_o,
  output logic ring2_update_o,
  input wire logic ring2_so_i,
  output logic cfg_wr_data_o,
  output logic cfg_wr_strobe_o,
  input wire logic cfg_rd_data_i,
  output logic cfg_rd_strobe_o
);

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] pin_lvl_reg;
  logic [3:0] pin_lvl_next;
  logic [1:0] ctrl_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  bst_tap_state_t state_reg;
  bst_tap_state_t state_next;
  logic [`BST_IR_W-1:0] ir_sh_reg;
  logic [`BST_IR_W-1:0] ir_reg;
  logic bypass_reg;
  logic tdo_reg;
  logic tdo_oe_reg;
  wire [`BST_NUM_PADS:0] chain;

  // Pin inputs: three flops; a change counts when the last two agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= `BST_PIN_RESET;
      sync2_reg <= `BST_PIN_RESET;
      sync3_reg <= `BST_PIN_RESET;
    end else begin
      sync1_reg <= {reconfigure_pin_n_i, tck_i, tms_i, tdi_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign pin_lvl_next = (sync2_reg & sync3_reg) |
                        (pin_lvl_reg & (sync2_reg | sync3_reg));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_lvl_reg <= `BST_PIN_RESET;
    end else begin
      pin_lvl_reg <= pin_lvl_next;
    end
  end

  wire tck_lvl = pin_lvl_reg[`BST_PIN_TCK];
  wire tck_lvl_next = pin_lvl_next[`BST_PIN_TCK];
  wire tck_rise = tck_lvl_next & ~tck_lvl;
  wire tck_fall = ~tck_lvl_next & tck_lvl;
  wire tms_lvl = pin_lvl_reg[`BST_PIN_TMS];
  wire tdi_lvl = pin_lvl_reg[`BST_PIN_TDI];
  wire reconfigure_pin_low = ~pin_lvl_reg[`BST_PIN_RECONFIGURE_PIN];

  // Activity: always before and during configuration, then by option.
  wire keep_opt = ctrl_reg[`BST_CTRL_KEEP_BIT];
  wire rdbk_opt = ctrl_reg[`BST_CTRL_RDBK_BIT];
  wire active = ~config_done_i | keep_opt;
  wire tap_rst = rst_i | reconfigure_pin_low | ~active;

  // Wishbone classic slave; every access acked one cycle after request.
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire hit_ctrl = wb_adr_i == `BST_ADR_CTRL;
  wire hit_status = wb_adr_i == `BST_ADR_STATUS;
  wire ctrl_wr = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & hit_ctrl &
                 wb_sel_i[0];
  wire [31:0] status_word = {23'h0, config_done_i, active,
                             ir_reg, state_reg};
  wire [31:0] rd_word = hit_ctrl ? {30'h0, ctrl_reg} :
                        hit_status ? status_word : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `BST_CTRL_RESET;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= wb_req;
      if (ctrl_wr) begin
        ctrl_reg <= wb_dat_i[1:0];
      end
      if (wb_req & ~wb_we_i) begin
        dat_reg <= rd_word;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Test port state machine.
  always_comb begin
    case (state_reg)
      TEST_LOGIC_RESET: begin
        state_next = tms_lvl ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      end
      RUN_TEST_IDLE: begin
        state_next = tms_lvl ? SELECT_DR : RUN_TEST_IDLE;
      end
      SELECT_DR: begin
        state_next = tms_lvl ? SELECT_IR : CAPTURE_DR;
      end
      CAPTURE_DR: begin
        state_next = tms_lvl ? EXIT1_DR : SHIFT_DR;
      end
      SHIFT_DR: begin
        state_next = tms_lvl ? EXIT1_DR : SHIFT_DR;
      end
      EXIT1_DR: begin
        state_next = tms_lvl ? UPDATE_DR : PAUSE_DR;
      end
      PAUSE_DR: begin
        state_next = tms_lvl ? EXIT2_DR : PAUSE_DR;
      end
      EXIT2_DR: begin
        state_next = tms_lvl ? UPDATE_DR : SHIFT_DR;
      end
      UPDATE_DR: begin
        state_next = tms_lvl ? SELECT_DR : RUN_TEST_IDLE;
      end
      SELECT_IR: begin
        state_next = tms_lvl ? TEST_LOGIC_RESET : CAPTURE_IR;
      end
      CAPTURE_IR: begin
        state_next = tms_lvl ? EXIT1_IR : SHIFT_IR;
      end
      SHIFT_IR: begin
        state_next = tms_lvl ? EXIT1_IR : SHIFT_IR;
      end
      EXIT1_IR: begin
        state_next = tms_lvl ? UPDATE_IR : PAUSE_IR;
      end
      PAUSE_IR: begin
        state_next = tms_lvl ? EXIT2_IR : PAUSE_IR;
      end
      EXIT2_IR: begin
        state_next = tms_lvl ? UPDATE_IR : SHIFT_IR;
      end
      UPDATE_IR: begin
        state_next = tms_lvl ? SELECT_DR : RUN_TEST_IDLE;
      end
      default: begin
        state_next = TEST_LOGIC_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (tap_rst) begin
      state_reg <= TEST_LOGIC_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  wire in_cap_dr = state_reg == CAPTURE_DR;
  wire in_sh_dr = state_reg == SHIFT_DR;
  wire in_up_dr = state_reg == UPDATE_DR;
  wire in_sh_ir = state_reg == SHIFT_IR;

  // Instruction decode.
  wire sel_extest = ir_reg == `BST_IR_EXTEST;
  wire sel_sample = ir_reg == `BST_IR_SAMPLE;
  wire sel_ring1 = ir_reg == `BST_IR_RING1;
  wire sel_ring2 = ir_reg == `BST_IR_RING2;
  wire sel_cfg_wr = ir_reg == `BST_IR_CFG_WRITE;
  wire sel_cfg_rd = (ir_reg == `BST_IR_CFG_READ) & config_done_i;
  wire sel_bsr = sel_extest | sel_sample;
  // Bypass, the reserved code, the configuration write code and an early read use the bypass flop.
  wire sel_bypass = ~(sel_bsr | sel_ring1 | sel_ring2 | sel_cfg_rd);
  wire mode = sel_extest;

  // Instruction register; no identification code is ever loaded.
  always_ff @(posedge clk_i) begin
    if (tap_rst) begin
      ir_sh_reg <= `BST_IR_RESET;
      ir_reg <= `BST_IR_RESET;
    end else begin
      if (tck_rise & (state_reg == CAPTURE_IR)) begin
        ir_sh_reg <= `BST_IR_CAPTURE;
      end else if (tck_rise & in_sh_ir) begin
        ir_sh_reg <= {tdi_lvl, ir_sh_reg[`BST_IR_W-1:1]};
      end
      if (tck_fall & (state_reg == UPDATE_IR)) begin
        ir_reg <= ir_sh_reg;
      end
    end
  end

  // Single-flop bypass register.
  always_ff @(posedge clk_i) begin
    if (tap_rst) begin
      bypass_reg <= 1'b0;
    end else if (tck_rise & in_cap_dr) begin
      bypass_reg <= 1'b0;
    end else if (tck_rise & in_sh_dr) begin
      bypass_reg <= tdi_lvl;
    end
  end

  // Boundary chain, pad 0 top-left first, last pad at the left-top end.
  wire bsr_cap = tck_rise & in_cap_dr & sel_bsr;
  wire bsr_shift = tck_rise & in_sh_dr & sel_bsr;
  wire bsr_update = tck_fall & in_up_dr & sel_bsr;

  assign chain[0] = tdi_lvl;

  genvar gi;
  generate
    for (gi = 0; gi < `BST_NUM_PADS; gi = gi + 1) begin : g_pad
      bst_cell u_cell (
        .clk_i(clk_i),
        .rst_i(tap_rst),
        .capture_i(bsr_cap),
        .shift_i(bsr_shift),
        .update_i(bsr_update),
        .mode_i(mode),
        .scan_i(chain[gi]),
        .pad_in_i(pad_in_i[gi]),
        .core_out_i(core_out_i[gi]),
        .core_oe_i(core_oe_i[gi]),
        .scan_o(chain[gi+1]),
        .pad_out_o(pad_out_o[gi]),
        .pad_oe_o(pad_oe_o[gi])
      );
    end
  endgenerate

  // Internal scan rings and the configuration paths.
  wire dr_cap = tck_rise & in_cap_dr;
  wire dr_shift = tck_rise & in_sh_dr;
  wire dr_update = tck_fall & in_up_dr;

  assign ring_si_o = tdi_lvl;
  assign ring1_capture_o = dr_cap & sel_ring1;
  assign ring1_shift_o = dr_shift & sel_ring1;
  assign ring1_update_o = dr_update & sel_ring1;
  assign ring2_capture_o = dr_cap & sel_ring2;
  assign ring2_shift_o = dr_shift & sel_ring2;
  assign ring2_update_o = dr_update & sel_ring2;
  assign cfg_wr_data_o = tdi_lvl;
  assign cfg_wr_strobe_o = dr_shift & sel_cfg_wr & active;
  assign cfg_rd_strobe_o = dr_shift & sel_cfg_rd;

  // Serial output select for the shared output pad.
  wire dr_out = sel_bsr ? chain[`BST_NUM_PADS] :
                sel_ring1 ? ring1_so_i :
                sel_ring2 ? ring2_so_i :
                sel_cfg_rd ? cfg_rd_data_i : bypass_reg;
  wire sh_out = in_sh_ir ? ir_sh_reg[0] : dr_out;
  wire shifting = in_sh_ir | in_sh_dr;

  always_ff @(posedge clk_i) begin
    if (rst_i | reconfigure_pin_low) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (~active) begin
      tdo_reg <= readback_data_i;
      tdo_oe_reg <= rdbk_opt;
    end else if (tck_fall) begin
      tdo_reg <= sh_out;
      tdo_oe_reg <= shifting;
    end
  end

  assign tdo_o = tdo_reg;
  assign tdo_oe_o = tdo_oe_reg;
  assign user_io_en_o = ~active;

endmodule : bst_test_port

// >>> bst_cfg.svh
`ifndef BST_CFG_SVH
`define BST_CFG_SVH

`define BST_IR_W 3
`define BST_IR_EXTEST 3'h0
`define BST_IR_RING1 3'h1
`define BST_IR_CFG_WRITE 3'h2
`define BST_IR_RESERVED 3'h3
`define BST_IR_SAMPLE 3'h4
`define BST_IR_RING2 3'h5
`define BST_IR_CFG_READ 3'h6
`define BST_IR_BYPASS 3'h7
`define BST_IR_CAPTURE 3'h1
`define BST_IR_RESET 3'h7

`define BST_NUM_PADS 8

`define BST_ADR_CTRL 8'h00
`define BST_ADR_STATUS 8'h04
`define BST_CTRL_KEEP_BIT 0
`define BST_CTRL_RDBK_BIT 1
`define BST_CTRL_RESET 2'h0
`define BST_ST_STATE_LSB 0
`define BST_ST_IR_LSB 4
`define BST_ST_ACTIVE_BIT 7
`define BST_ST_DONE_BIT 8

`define BST_PIN_RECONFIGURE_PIN 3
`define BST_PIN_TCK 2
`define BST_PIN_TMS 1
`define BST_PIN_TDI 0
`define BST_PIN_RESET 4'h9

`endif

// >>> bst_pkg.sv
package bst_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } bst_tap_state_t;

endpackage : bst_pkg

// >>> bst_cell.sv
`timescale 1ns/1ps

module bst_cell (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic capture_i,
  input wire logic shift_i,
  input wire logic update_i,
  input wire logic mode_i,
  input wire logic scan_i,
  input wire logic pad_in_i,
  input wire logic core_out_i,
  input wire logic core_oe_i,
  output logic scan_o,
  output logic pad_out_o,
  output logic pad_oe_o
);

  logic ctrl_sh_reg;
  logic data_sh_reg;
  logic ctrl_up_reg;
  logic data_up_reg;
  wire drive_direction_flag;
  wire data_capture;

  // The control cell picks what the data cell captures.
  assign drive_direction_flag = mode_i ? ctrl_up_reg : core_oe_i;
  assign data_capture = drive_direction_flag ? core_out_i : pad_in_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_sh_reg <= 1'b0;
      data_sh_reg <= 1'b0;
    end else if (capture_i) begin
      ctrl_sh_reg <= drive_direction_flag;
      data_sh_reg <= data_capture;
    end else if (shift_i) begin
      ctrl_sh_reg <= scan_i;
      data_sh_reg <= ctrl_sh_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_up_reg <= 1'b0;
      data_up_reg <= 1'b0;
    end else if (update_i) begin
      ctrl_up_reg <= ctrl_sh_reg;
      data_up_reg <= data_sh_reg;
    end
  end

  assign scan_o = data_sh_reg;
  assign pad_oe_o = mode_i ? ctrl_up_reg : core_oe_i;
  assign pad_out_o = mode_i ? data_up_reg : core_out_i;

endmodule : bst_cell

// >>> bst_test_port_properties.sv
`timescale 1ns/1ps

module bst_test_port_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tdo_oe_o,
  input wire logic reconfigure_pin_n_i,
  input wire logic config_done_i,
  input wire logic user_io_en_o,
  input wire logic [7:0] core_out_i,
  input wire logic [7:0] pad_out_o,
  input wire logic ring1_shift_o,
  input wire logic ring2_shift_o,
  input wire logic cfg_wr_strobe_o,
  input wire logic cfg_rd_strobe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  reset_oe_a: assert property (!reconfigure_pin_n_i [*6] |-> !tdo_oe_o)
    else $error("tdo driven in reset");
  reset_pads_a: assert property (
    !reconfigure_pin_n_i [*6] |-> pad_out_o == core_out_i)
    else $error("pads not core driven");
  user_io_a: assert property (user_io_en_o |-> config_done_i)
    else $error("user io before done");
  ring_excl_a: assert property (!(ring1_shift_o && ring2_shift_o))
    else $error("both rings shift");
  rd_done_a: assert property (cfg_rd_strobe_o |-> config_done_i)
    else $error("read before done");
  wr_pulse_a: assert property (cfg_wr_strobe_o |=> !cfg_wr_strobe_o)
    else $error("write strobe long");
endmodule : bst_test_port_properties

bind bst_test_port bst_test_port_properties u_props (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tdo_oe_o, .reconfigure_pin_n_i,
  .config_done_i, .user_io_en_o, .core_out_i, .pad_out_o, .ring1_shift_o,
  .ring2_shift_o, .cfg_wr_strobe_o, .cfg_rd_strobe_o);

// >>> bst_host.sv
`timescale 1ns/1ps

module bst_host (
  input wire logic clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // Mode and data change as the test clock falls.
  task step(input logic m, input logic d, output logic q);
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    q = tdo_i;
    tck_o <= 1'b0;
  endtask : step

  task tap_reset;
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : tap_reset

  task ir(input logic [2:0] c, output logic [2:0] cap);
    logic q;
    step(1'b1, 1'b0, q);
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < 3; i++) step(i == 2, c[i], cap[i]);
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : ir

  task dr(input int n, input logic [15:0] din, output logic [15:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : dr
endmodule : bst_host

// >>> bst_test_port_tb.sv
`timescale 1ns/1ps
`include "bst_cfg.svh"

module bst_test_port_tb;
  import bst_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0, wb_ack_o, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o;
  logic reconfigure_pin_n_i = 1'b1, config_done_i = 1'b0, user_io_en_o;
  logic readback_data_i = 1'b0, ring1_so_i = 1'b0, ring2_so_i = 1'b0;
  logic cfg_rd_data_i = 1'b0, ring1_shift_o, ring2_shift_o;
  logic cfg_wr_strobe_o, cfg_rd_strobe_o, ring_si_o, ring1_capture_o;
  logic ring1_update_o, ring2_capture_o, ring2_update_o, cfg_wr_data_o;
  logic [3:0] si;
  logic [7:0] wb_adr_i = 8'h00, pad_in_i = 8'h3c, core_out_i = 8'h96;
  logic [7:0] core_oe_i = 8'hf0, pad_out_o, pad_oe_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'hf;
  logic [15:0] so, wd;
  int c1 = 0, c2 = 0;
  logic [2:0] cap;
  int mismatches = 0, cmp_count = 0, n1 = 0, n2 = 0, nw = 0, nr = 0, b;

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n1 <= n1 + ring1_shift_o;
    n2 <= n2 + ring2_shift_o;
    nw <= nw + cfg_wr_strobe_o;
    nr <= nr + cfg_rd_strobe_o;
    c1 <= c1 + ring1_capture_o + ring1_update_o;
    c2 <= c2 + ring2_capture_o + ring2_update_o;
    if (ring1_shift_o | ring2_shift_o) si <= {ring_si_o, si[3:1]};
    if (cfg_wr_strobe_o) wd <= {cfg_wr_data_o, wd[15:1]};
  end

  bst_test_port u_bst_test_port (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
    .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tck_i,
    .tms_i, .tdi_i, .tdo_o, .tdo_oe_o, .reconfigure_pin_n_i, .config_done_i,
    .readback_data_i, .user_io_en_o, .pad_in_i, .core_out_i, .core_oe_i,
    .pad_out_o, .pad_oe_o, .ring_si_o, .ring1_capture_o, .ring1_shift_o,
    .ring1_update_o, .ring1_so_i, .ring2_capture_o, .ring2_shift_o,
    .ring2_update_o, .ring2_so_i, .cfg_wr_data_o, .cfg_wr_strobe_o,
    .cfg_rd_data_i, .cfg_rd_strobe_o);
  // A released test output reads as its pull-up level.
  bst_host u_bst_host (.clk_i, .tdo_i(tdo_oe_o ? tdo_o : 1'b1),
    .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i));

  task check(input string what, input logic [31:0] seen, input logic [31:0] e);
    cmp_count++;
    if (seen !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, e, seen);
    end
  endtask : check

  task results;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++k < 20);
    if (k >= 20) begin
      mismatches++;
      results;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  function automatic logic [15:0] chain(input logic [7:0] oe, input logic [7:0] d);
    logic [15:0] c;
    for (int p = 0; p < 8; p++) begin
      c[2*(7-p)] = d[p];
      c[2*(7-p)+1] = oe[p];
    end
    return c;
  endfunction : chain

  task t_regs;
    wb(1'b1, 8'h10, 32'hffffffff);
    wb(1'b0, 8'h10, 32'h0);
    check("unmapped", rd, 32'h0);
    wb(1'b0, `BST_ADR_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    u_bst_host.tap_reset;
    wb(1'b0, `BST_ADR_STATUS, 32'h0);
    check("status", rd, 32'(RUN_TEST_IDLE) | 32'hf0);
  endtask : t_regs

  task t_bypass;
    for (int i = 0; i < 2; i++) begin
      u_bst_host.ir(i ? `BST_IR_RESERVED : `BST_IR_BYPASS, cap);
      check("ir capture", cap, 3'h1);
      u_bst_host.dr(8, 16'h00b3, so);
      check("bypass", so, 16'h0066);
      check("core pads", pad_out_o, core_out_i);
    end
  endtask : t_bypass

  task t_boundary;
    u_bst_host.ir(`BST_IR_SAMPLE, cap);
    u_bst_host.dr(16, chain(8'h0f, 8'ha5), so);
    check("sample", so, chain(8'hf0, 8'h9c));
    check("sample oe", pad_oe_o, 8'hf0);
    u_bst_host.ir(`BST_IR_EXTEST, cap);
    check("extest oe", pad_oe_o, 8'h0f);
    check("extest out", pad_out_o, 8'ha5);
    u_bst_host.dr(16, chain(8'h0f, 8'ha5), so);
    check("extest cap", so, chain(8'h0f, 8'h36));
    reconfigure_pin_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    check("reconf oe", pad_oe_o, 8'hf0);
    wb(1'b0, `BST_ADR_STATUS, 32'h0);
    check("reconf st", rd, 32'h0f0);
    reconfigure_pin_n_i <= 1'b1;
    u_bst_host.tap_reset;
  endtask : t_boundary

  task t_inner;
    ring1_so_i <= 1'b1;
    b = n1;
    u_bst_host.ir(`BST_IR_RING1, cap);
    u_bst_host.dr(4, 16'h9, so);
    check("ring1", {so[3:0], 8'(n1 - b)}, 12'hf04);
    check("ring1 in", {si, 4'(c1)}, 8'h92);
    b = n2;
    u_bst_host.ir(`BST_IR_RING2, cap);
    u_bst_host.dr(4, 16'h6, so);
    check("ring2", {so[3:0], 8'(n2 - b)}, 12'h004);
    check("ring2 in", {si, 4'(c2)}, 8'h62);
    b = nw;
    u_bst_host.ir(`BST_IR_CFG_WRITE, cap);
    u_bst_host.dr(5, 16'h15, so);
    check("cfg write", nw - b, 5);
    check("cfg data", wd[15:11], 5'h15);
    b = nr;
    cfg_rd_data_i <= 1'b1;
    u_bst_host.ir(`BST_IR_CFG_READ, cap);
    u_bst_host.dr(4, 16'h0, so);
    check("early read", so, 16'h0);
    wb(1'b1, `BST_ADR_CTRL, 32'h1);
    config_done_i <= 1'b1;
    u_bst_host.dr(4, 16'h0, so);
    check("cfg read", {so[3:0], 8'(nr - b)}, 12'hf04);
  endtask : t_inner

  task t_off;
    wb(1'b1, `BST_ADR_CTRL, 32'h0);
    repeat (4) @(posedge clk_i);
    check("free pins", {user_io_en_o, tdo_oe_o}, 2'h2);
    readback_data_i <= 1'b1;
    wb(1'b1, `BST_ADR_CTRL, 32'h2);
    repeat (4) @(posedge clk_i);
    check("readback 1", {tdo_oe_o, tdo_o}, 2'h3);
    readback_data_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("readback 0", {tdo_oe_o, tdo_o}, 2'h2);
    wb(1'b0, `BST_ADR_STATUS, 32'h0);
    check("inactive", rd[8:7], 2'h2);
  endtask : t_off

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_regs;
    t_bypass;
    t_boundary;
    t_inner;
    t_off;
    results;
  end
endmodule : bst_test_port_tb
